// File: design/qec_pkg.sv
// package: register map, field positions, reset values and timing of the encoder counter
package qec_pkg;
   // register byte offsets
   localparam logic [7:0] QEC_OFS_COUNT    = 8'h00;
   localparam logic [7:0] QEC_OFS_TOTAL    = 8'h04;
   localparam logic [7:0] QEC_OFS_CTRL     = 8'h08;
   localparam logic [7:0] QEC_OFS_STATUS   = 8'h0c;
   localparam logic [7:0] QEC_OFS_IRQCLR   = 8'h10;
   localparam logic [7:0] QEC_OFS_IRQEN    = 8'h14;
   localparam logic [7:0] QEC_OFS_INPUTS   = 8'h18;
   localparam int         QEC_ADDR_W       = 8;
   // control field positions
   localparam int QEC_CTL_ARM      = 0;
   localparam int QEC_CTL_CNTRST   = 1;
   localparam int QEC_CTL_UPDOWN   = 2;
   localparam int QEC_CTL_FILTER   = 3;
   localparam int QEC_CTL_IDXPOL   = 4;
   localparam int QEC_CTL_GATEUSE  = 5;
   localparam int QEC_CTL_GATEPOL  = 6;
   localparam int QEC_CTL_W        = 7;
   localparam logic [6:0] QEC_CTL_RESET = 7'h08;
   // event bits: index zeroing done, count step, illegal transition
   localparam int QEC_EV_ZERO  = 0;
   localparam int QEC_EV_STEP  = 1;
   localparam int QEC_EV_ERR   = 2;
   localparam int QEC_EV_W     = 3;
   // filter lengths in sample clocks
   localparam logic [3:0] QEC_FILT_LONG  = 4'hf;
   localparam logic [3:0] QEC_FILT_SHORT = 4'h3;
   // sample clock rates (Hz) of the two card families
   localparam int QEC_CLK_PCI_HZ = 33000000;
   localparam int QEC_CLK_PAR_HZ = 50000000;
   localparam logic [1:0] QEC_RESP_OKAY   = 2'b00;
   localparam logic [1:0] QEC_RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic phaseA;
      logic phaseB;
      logic index;
      logic gate;
   } qec_enc_t;

   typedef struct packed {
      logic       arm;
      logic       cntRst;
      logic       upDown;
      logic       filter;
      logic       idxPol;
      logic       gateUse;
      logic       gatePol;
   } qec_ctl_t;
endpackage

// File: design/qec_counter.sv
// encoder counter core with filtered inputs, index zeroing and an AXI4-Lite register slave
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - takes phase A, B, index; build option adds an index gate input.
// - keeps signed 32-bit count since last reset or index zeroing.
// - armed zeroing clears count on next qualified index, then clears arm bit.
// - second signed 32-bit total counts all steps, zeroed only by sys_rst, never by index or reset bit.
// - count held zero while reset bit is true; software must release it.
// - style bit defaults false for quadrature; true selects up/down on A.
// - filter bit true needs 15 stable clocks, false needs 3; shorter pulses dropped.
// - sample clock is 33 MHz on PCI cards, 50 MHz on parallel card.
// - polarity bit true uses rising index edge, false uses falling edge.
// - gate use bit true lets index act only while gate is active.
// - gate polarity bit true makes gate active low, false active high.
// - quadrature counts both edges of both phases, four per line cycle.
// - up/down mode counts each rising A edge, B level sets direction.
module qec_counter
   import qec_pkg::*;
#(
   parameter bit HAS_GATE  = 1'b1,
   parameter int CLK_HZ    = QEC_CLK_PCI_HZ
)(
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire qec_enc_t              encIn,
   input  wire logic [QEC_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [QEC_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic                       irq
);

   //////////////////////////////////////////////////////////////////////////
   // input filter
   logic [2:0]  rawIn;
   logic [2:0]  filtIn_r;
   logic [3:0]  filtCnt_r [3];
   logic [3:0]  filtLen;
   logic        gateLvl;

   assign gateLvl = HAS_GATE ? encIn.gate : 1'b0;
   assign rawIn   = {encIn.index, encIn.phaseB, encIn.phaseA};

   qec_ctl_t    ctl_r;
   assign filtLen = ctl_r.filter ? QEC_FILT_LONG : QEC_FILT_SHORT;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               filtCnt_r[gi] <= 4'h0;
               filtIn_r[gi]  <= 1'b0;
            end else if (rawIn[gi] == filtIn_r[gi]) begin
               filtCnt_r[gi] <= 4'h0;
            end else if (filtCnt_r[gi] + 4'h1 >= filtLen) begin
               filtCnt_r[gi] <= 4'h0;
               filtIn_r[gi]  <= rawIn[gi];
            end else begin
               filtCnt_r[gi] <= filtCnt_r[gi] + 4'h1;
            end
         end
      end
   endgenerate

   logic [2:0] prevIn_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prevIn_r <= 3'h0;
      end else begin
         prevIn_r <= filtIn_r;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // step decode
   logic        stepUp;
   logic        stepDn;
   logic        badStep;
   logic        aNow;
   logic        bNow;
   logic        aOld;
   logic        bOld;

   assign aNow = filtIn_r[0];
   assign bNow = filtIn_r[1];
   assign aOld = prevIn_r[0];
   assign bOld = prevIn_r[1];

   always_comb begin
      stepUp  = 1'b0;
      stepDn  = 1'b0;
      badStep = 1'b0;
      if (ctl_r.upDown) begin
         if (aNow && !aOld) begin
            stepUp = !bNow;
            stepDn = bNow;
         end
      end else if ((aNow != aOld) && (bNow != bOld)) begin
         badStep = 1'b1;
      end else if ((aNow != aOld) || (bNow != bOld)) begin
         stepUp = !(aOld ^ bNow);
         stepDn = aOld ^ bNow;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // index qualification
   logic        idxEdge;
   logic        gateOk;
   logic        idxHit;

   assign idxEdge = ctl_r.idxPol ? (filtIn_r[2] && !prevIn_r[2])
                                 : (!filtIn_r[2] && prevIn_r[2]);
   assign gateOk  = !ctl_r.gateUse || (gateLvl ^ ctl_r.gatePol);
   assign idxHit  = ctl_r.arm && idxEdge && gateOk;

   //////////////////////////////////////////////////////////////////////////
   // counters
   logic [31:0] count_r;
   logic [31:0] total_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count_r <= 32'h0;
      end else if (ctl_r.cntRst || idxHit) begin
         count_r <= 32'h0;
      end else if (stepUp) begin
         count_r <= count_r + 32'h1;
      end else if (stepDn) begin
         count_r <= count_r - 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         total_r <= 32'h0;
      end else if (stepUp) begin
         total_r <= total_r + 32'h1;
      end else if (stepDn) begin
         total_r <= total_r - 32'h1;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic                  awHeld_r;
   logic                  wHeld_r;
   logic [QEC_ADDR_W-1:0] awAddr_r;
   logic [31:0]           wData_r;
   logic [3:0]            wStrb_r;
   logic                  doWrite;
   logic                  wrCtl;
   logic                  wrClr;
   logic                  wrEn;
   logic [QEC_EV_W-1:0]   evStat_r;
   logic [QEC_EV_W-1:0]   evEn_r;
   logic [QEC_EV_W-1:0]   evNow;

   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign wrCtl   = doWrite && (awAddr_r == QEC_OFS_CTRL) && wStrb_r[0];
   assign wrClr   = doWrite && (awAddr_r == QEC_OFS_IRQCLR) && wStrb_r[0];
   assign wrEn    = doWrite && (awAddr_r == QEC_OFS_IRQEN) && wStrb_r[0];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awHeld_r      <= 1'b0;
         awAddr_r      <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_r      <= 1'b1;
         awAddr_r      <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (doWrite) begin
         awHeld_r      <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld_r && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wHeld_r      <= 1'b0;
         wData_r      <= 32'h0;
         wStrb_r      <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_r      <= 1'b1;
         wData_r      <= s_axi_wdata;
         wStrb_r      <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (doWrite) begin
         wHeld_r      <= 1'b0;
      end else begin
         s_axi_wready <= !wHeld_r && !s_axi_bvalid;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= QEC_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         case (awAddr_r)
            QEC_OFS_CTRL, QEC_OFS_IRQCLR, QEC_OFS_IRQEN: s_axi_bresp <= QEC_RESP_OKAY;
            QEC_OFS_COUNT, QEC_OFS_TOTAL, QEC_OFS_STATUS,
            QEC_OFS_INPUTS: s_axi_bresp <= QEC_RESP_OKAY;
            default: s_axi_bresp <= QEC_RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control word packed and unpacked by field position
   logic [QEC_CTL_W-1:0] ctlWord;
   qec_ctl_t             ctlWr;
   qec_ctl_t             ctlRst;

   always_comb begin
      ctlWord                  = '0;
      ctlWord[QEC_CTL_ARM]     = ctl_r.arm;
      ctlWord[QEC_CTL_CNTRST]  = ctl_r.cntRst;
      ctlWord[QEC_CTL_UPDOWN]  = ctl_r.upDown;
      ctlWord[QEC_CTL_FILTER]  = ctl_r.filter;
      ctlWord[QEC_CTL_IDXPOL]  = ctl_r.idxPol;
      ctlWord[QEC_CTL_GATEUSE] = ctl_r.gateUse;
      ctlWord[QEC_CTL_GATEPOL] = ctl_r.gatePol;
   end

   always_comb begin
      ctlWr.arm     = wData_r[QEC_CTL_ARM];
      ctlWr.cntRst  = wData_r[QEC_CTL_CNTRST];
      ctlWr.upDown  = wData_r[QEC_CTL_UPDOWN];
      ctlWr.filter  = wData_r[QEC_CTL_FILTER];
      ctlWr.idxPol  = wData_r[QEC_CTL_IDXPOL];
      ctlWr.gateUse = wData_r[QEC_CTL_GATEUSE];
      ctlWr.gatePol = wData_r[QEC_CTL_GATEPOL];
   end

   always_comb begin
      ctlRst.arm     = QEC_CTL_RESET[QEC_CTL_ARM];
      ctlRst.cntRst  = QEC_CTL_RESET[QEC_CTL_CNTRST];
      ctlRst.upDown  = QEC_CTL_RESET[QEC_CTL_UPDOWN];
      ctlRst.filter  = QEC_CTL_RESET[QEC_CTL_FILTER];
      ctlRst.idxPol  = QEC_CTL_RESET[QEC_CTL_IDXPOL];
      ctlRst.gateUse = QEC_CTL_RESET[QEC_CTL_GATEUSE];
      ctlRst.gatePol = QEC_CTL_RESET[QEC_CTL_GATEPOL];
   end

   // control register; arm clears itself on a hit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_r <= ctlRst;
      end else begin
         if (wrCtl) begin
            ctl_r <= ctlWr;
         end
         if (idxHit) begin
            ctl_r.arm <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // interrupts
   always_comb begin
      evNow = '0;
      evNow[QEC_EV_ZERO] = idxHit;
      evNow[QEC_EV_STEP] = stepUp || stepDn;
      evNow[QEC_EV_ERR]  = badStep;
   end

   // set wins over clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evStat_r <= '0;
         evEn_r   <= '0;
         irq      <= 1'b0;
      end else begin
         evStat_r <= (evStat_r & ~(wrClr ? wData_r[QEC_EV_W-1:0] : '0)) | evNow;
         if (wrEn) begin
            evEn_r <= wData_r[QEC_EV_W-1:0];
         end
         irq <= |(evStat_r & evEn_r);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // read channel
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= QEC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= QEC_RESP_OKAY;
         case (s_axi_araddr)
            QEC_OFS_COUNT:  s_axi_rdata <= count_r;
            QEC_OFS_TOTAL:  s_axi_rdata <= total_r;
            QEC_OFS_CTRL:   s_axi_rdata <= {25'h0, ctlWord};
            QEC_OFS_STATUS: s_axi_rdata <= {29'h0, evStat_r};
            QEC_OFS_IRQCLR: s_axi_rdata <= 32'h0;
            QEC_OFS_IRQEN:  s_axi_rdata <= {29'h0, evEn_r};
            QEC_OFS_INPUTS: s_axi_rdata <= {28'h0, gateLvl, filtIn_r};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= QEC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// File: verification/qec_counter_properties.sv
// checker: bus and reset properties of the encoder counter
`timescale 1ns/1ps
module qec_counter_properties
   import qec_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_bready,
   input wire logic [QEC_ADDR_W-1:0] s_axi_araddr,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  s_axi_rready,
   input wire logic                  irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   rst_quiet_a: assert property ($fell(sys_rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("bus or irq active after reset");
   resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response kept after handshake");
   rdata_hold_a: assert property (s_axi_rvalid |=> !s_axi_rvalid || $stable(s_axi_rdata))
      else $error("read data changed while valid");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1b
      |=> s_axi_rresp == QEC_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:120] s_axi_bvalid)
      else $error("write response missing");
   cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == QEC_OFS_COUNT);
   cover property ($rose(irq));
   cover property (s_axi_rvalid && s_axi_rresp == QEC_RESP_SLVERR);
endmodule
bind qec_counter qec_counter_properties u_qec_counter_properties (
   .clk           (clk),
   .sys_rst       (sys_rst),
   .s_axi_awvalid (s_axi_awvalid),
   .s_axi_awready (s_axi_awready),
   .s_axi_wready  (s_axi_wready),
   .s_axi_bvalid  (s_axi_bvalid),
   .s_axi_bready  (s_axi_bready),
   .s_axi_araddr  (s_axi_araddr),
   .s_axi_arvalid (s_axi_arvalid),
   .s_axi_arready (s_axi_arready),
   .s_axi_rdata   (s_axi_rdata),
   .s_axi_rresp   (s_axi_rresp),
   .s_axi_rvalid  (s_axi_rvalid),
   .s_axi_rready  (s_axi_rready),
   .irq           (irq)
);

// File: verification/qec_enc_model.sv
// encoder partner model: gray phases, index and gate levels
`timescale 1ns/1ps
module qec_enc_model
   import qec_pkg::*;
(
   input wire logic clk,
   output qec_enc_t enc
);
   initial enc = '0;
   task automatic put(input logic [3:0] v, input int hold);
      enc <= v;
      repeat (hold) @(posedge clk);
   endtask
   task automatic pin(input logic i, input logic gt, input int hold);
      put({enc.phaseA, enc.phaseB, i, gt}, hold);
   endtask
   task automatic move(input bit up, input int hold, input int n);
      logic [1:0] p;
      for (int k = 0; k < n; k++) begin
         p = {enc.phaseB, enc.phaseA};
         p = up ? {p[0], ~p[1]} : {~p[0], p[1]};
         put({p[0], p[1], enc.index, enc.gate}, hold);
      end
   endtask
endmodule

// File: verification/qec_counter_tb.sv
// testbench: register level tests of the encoder counter
`timescale 1ns/1ps
module qec_counter_tb import qec_pkg::*;;
   logic        clk, sys_rst, awValid, awReady, wValid, wReady, bValid, bReady;
   logic        arValid, arReady, rValid, rReady, irq;
   logic [7:0]  awAddr, arAddr;
   logic [31:0] wData, rData, d, cnt, tot;
   logic [3:0]  wStrb;
   logic [1:0]  bResp, rResp, r;
   qec_enc_t    encIn, g;
   int          mismatches, samples_checked;
   logic [31:0] cs [7] = '{32'h11, 32'h01, 32'h31, 32'h31, 32'h71, 32'h71, 32'h10};
   logic [3:0]  ud [6] = '{4'h0, 4'h8, 4'h0, 4'h8, 4'h4, 4'hc};
   logic [6:0]  gs = 7'h18, zs = 7'h2b;
   qec_counter u_qec_counter (.clk(clk), .sys_rst(sys_rst), .encIn(encIn),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
      .s_axi_rready(rReady), .irq(irq));
   qec_enc_model u_qec_enc_model (.clk(clk), .enc(encIn));
   ////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic guard(input int t);
      if (t >= 99) begin
         mismatches++;
         end_of_test();
      end
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int t;
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      awAddr <= a;
      wData <= v;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      for (t = 0; t < 99 && (aw || w); t++) begin
         @(posedge clk);
         aw = aw && !awReady;
         w = w && !wReady;
         awValid <= aw;
         wValid <= w;
      end
      guard(t);
      for (t = 0; t < 99 && !bValid; t++) @(posedge clk);
      r = bResp;
      bReady <= 1'b0;
      guard(t);
   endtask
   task automatic rd(input logic [7:0] a);
      int t;
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      @(posedge clk);
      for (t = 0; t < 99 && !arReady; t++) @(posedge clk);
      arValid <= 1'b0;
      guard(t);
      for (t = 0; t < 99 && !rValid; t++) @(posedge clk);
      d = rData;
      r = rResp;
      rReady <= 1'b0;
      guard(t);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask
   // one step between rising and falling index edges: polarity decides the final count
   task automatic idx(input logic [31:0] c, input logic gt, input bit z);
      u_qec_enc_model.pin(1'b0, gt, 4);
      wr(QEC_OFS_CTRL, c);
      u_qec_enc_model.pin(1'b1, gt, 4);
      u_qec_enc_model.move(1'b1, 4, 1);
      u_qec_enc_model.pin(1'b0, gt, 4);
      cnt = z ? {31'h0, c[4]} : cnt + 1;
      tot = tot + 1;
      rc(QEC_OFS_COUNT, cnt);
      rc(QEC_OFS_CTRL, z ? c & ~32'h1 : c);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {sys_rst, mismatches, samples_checked, cnt, tot} = '0;
      sys_rst = 1'b1;
      {awValid, wValid, bReady, arValid, rReady} = '0;
      {awAddr, arAddr, wData} = '0;
      wStrb = 4'hf;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rc(QEC_OFS_CTRL, 32'h8);
      rc(QEC_OFS_TOTAL, 32'h0);
      rc(8'h1c, 32'h0);
      chk({30'h0, r}, {30'h0, QEC_RESP_SLVERR});
      wr(8'h1c, 32'h0);
      chk({30'h0, r}, {30'h0, QEC_RESP_SLVERR});
      $display("reset test done");
      wr(QEC_OFS_IRQEN, 32'h2);
      chk({30'h0, r}, {30'h0, QEC_RESP_OKAY});
      u_qec_enc_model.move(1'b1, 16, 4);
      rc(QEC_OFS_COUNT, 32'h4);
      chk({31'h0, irq}, 32'h1);
      u_qec_enc_model.move(1'b0, 16, 6);
      rc(QEC_OFS_COUNT, 32'hfffffffe);
      wr(QEC_OFS_IRQCLR, 32'h7);
      wr(QEC_OFS_IRQEN, 32'h0);
      u_qec_enc_model.move(1'b1, 16, 2);
      rc(QEC_OFS_STATUS, 32'h2);
      chk({31'h0, irq}, 32'h0);
      $display("quadrature test done");
      g = encIn;
      u_qec_enc_model.put(g ^ 4'h8, 14);
      u_qec_enc_model.put(g, 16);
      rc(QEC_OFS_COUNT, cnt);
      wr(QEC_OFS_CTRL, 32'h0);
      u_qec_enc_model.put(g ^ 4'h8, 2);
      u_qec_enc_model.put(g, 4);
      u_qec_enc_model.move(1'b1, 4, 4);
      cnt = cnt + 4;
      tot = tot + 4;
      rc(QEC_OFS_COUNT, cnt);
      g = encIn;
      u_qec_enc_model.put(g ^ 4'hc, 4);
      rc(QEC_OFS_COUNT, cnt);
      rc(QEC_OFS_STATUS, 32'h6);
      $display("filter test done");
      wr(QEC_OFS_CTRL, 32'h4);
      foreach (ud[i]) begin
         u_qec_enc_model.put(ud[i], 4);
      end
      cnt = cnt + 1;
      tot = tot + 1;
      rc(QEC_OFS_COUNT, cnt);
      $display("up down test done");
      for (int i = 0; i < 7; i++) begin
         idx(cs[i], gs[i], zs[i]);
      end
      rc(QEC_OFS_TOTAL, tot);
      $display("index test done");
      wr(QEC_OFS_CTRL, 32'h2);
      u_qec_enc_model.move(1'b1, 4, 3);
      tot = tot + 3;
      rc(QEC_OFS_COUNT, 32'h0);
      rc(QEC_OFS_CTRL, 32'h2);
      rc(QEC_OFS_TOTAL, tot);
      $display("count reset test done");
      u_qec_enc_model.put(4'h1, 4);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rc(QEC_OFS_COUNT, 32'h0);
      rc(QEC_OFS_TOTAL, 32'h0);
      rc(QEC_OFS_CTRL, 32'h8);
      rc(QEC_OFS_INPUTS, 32'h8);
      $display("mid reset test done");
      end_of_test();
   end
endmodule
